// [capture_pair.v]
/*
  A pair of input capture modules, odd and even, each with its own
  16-bit time base counter and a capture store. The pair can be joined
  into one 32-bit module. Control bits arrive as plain ports.
  Assumes all inputs are synchronous to clk_in and that time base ticks
  and sync events are one-cycle enable pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "capture_defs.vh"

//
// Contract
// - 16-bit counter runs and wraps on time base
// - Capture event stores present counter value
// - Store holds up to four captured values
// - Six clock sources, thirty-one sync sources selectable
// - Sync mode runs, sync event clears counter
// - Trigger mode holds counter until trigger event
// - No sync, no trigger bit means free run
// - Nonzero source picks sync or trigger mode
// - Zero source with trigger bit: software trigger
// - Cascade: odd low word, even high word
// - Odd counter wrap increments even counter
// - Cascade only when both enable bits set
// - Rising, falling, every edge, or every 4th/16th rising
// - Interrupt rate set apart from capture mode; every-edge mode here interrupts on each capture, ignoring the rate
// - Cascaded sync pair held clear until sync
// - Even trigger bit clear: even follows odd
// - Not-empty flag tracks stored values
// - Mode field selects off, edges, prescale, wake
// - Interrupt after 1 to 4 captures
// - Read-only overflow flag
module capture_pair #(
  parameter CW    = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire          clk_in,          // System clock, 20 MHz
  input  wire          rst_in,          // Synchronous reset, active high
  input  wire    [7:0] time_base_ticks_in, // Tick pulse per time base code
  input  wire   [31:0] sync_events_in,  // Event pulse per sync source code
  input  wire          sleep_in,        // Device in sleep or idle
  input  wire          x_pin_in,        // Odd module capture pin
  input  wire    [2:0] x_capture_mode_select_in,   // Odd mode field
  input  wire    [1:0] x_captures_per_interrupt_in, // Odd interrupt rate
  input  wire    [2:0] x_time_base_select_in,      // Odd clock source
  input  wire    [4:0] x_sync_source_select_in,    // Odd sync source
  input  wire          x_trigger_not_sync_select_in, // Odd trigger mode
  input  wire          x_trigger_set_in,  // Odd software trigger set
  input  wire          x_trigger_clr_in,  // Odd software trigger clear
  input  wire          x_cascade_enable_in, // Odd cascade bit
  input  wire          x_buffer_read_in,  // Odd buffer read strobe
  input  wire          y_pin_in,        // Even module capture pin
  input  wire    [2:0] y_capture_mode_select_in,   // Even mode field
  input  wire    [1:0] y_captures_per_interrupt_in, // Even interrupt rate
  input  wire    [2:0] y_time_base_select_in,      // Even clock source
  input  wire    [4:0] y_sync_source_select_in,    // Even sync source
  input  wire          y_trigger_not_sync_select_in, // Even trigger mode
  input  wire          y_trigger_set_in,  // Even software trigger set
  input  wire          y_trigger_clr_in,  // Even software trigger clear
  input  wire          y_cascade_enable_in, // Even cascade bit
  input  wire          y_buffer_read_in,  // Even buffer read strobe
  output wire [CW-1:0] x_buffer_out,      // Odd oldest captured value
  output wire          x_buffer_not_empty_flag_out, // Odd store not empty
  output wire          x_capture_overflow_flag_out, // Odd overflow flag
  output wire          x_trigger_running_status_out, // Odd trigger status
  output wire          x_irq_out,         // Odd interrupt pulse
  output wire [CW-1:0] x_capture_counter_out, // Odd counter value
  output wire [CW-1:0] y_buffer_out,      // Even oldest captured value
  output wire          y_buffer_not_empty_flag_out, // Even store not empty
  output wire          y_capture_overflow_flag_out, // Even overflow flag
  output wire          y_trigger_running_status_out, // Even trigger status
  output wire          y_irq_out,         // Even interrupt pulse
  output wire [CW-1:0] y_capture_counter_out  // Even counter value
);

  // Pair joins only when both modules ask for it
  wire casc = x_cascade_enable_in & y_cascade_enable_in;

  // Per-module controls; the even module takes the odd mode and rate in cascade
  wire [2:0] mode_w  [0:1];
  wire [1:0] cpi_w   [0:1];
  wire [2:0] tbsel_w [0:1];
  wire [4:0] sel_w   [0:1];
  wire [1:0] pin_v   = {y_pin_in, x_pin_in};
  wire [1:0] trig_v  = {y_trigger_not_sync_select_in, x_trigger_not_sync_select_in};
  wire [1:0] tset_v  = {y_trigger_set_in, x_trigger_set_in};
  wire [1:0] tclr_v  = {y_trigger_clr_in, x_trigger_clr_in};
  wire [1:0] read_v  = {y_buffer_read_in, x_buffer_read_in};

  assign mode_w[0]  = x_capture_mode_select_in;
  assign mode_w[1]  = casc ? x_capture_mode_select_in : y_capture_mode_select_in;
  assign cpi_w[0]   = x_captures_per_interrupt_in;
  assign cpi_w[1]   = casc ? x_captures_per_interrupt_in : y_captures_per_interrupt_in;
  assign tbsel_w[0] = x_time_base_select_in;
  assign tbsel_w[1] = y_time_base_select_in;
  assign sel_w[0]   = x_sync_source_select_in;
  assign sel_w[1]   = y_sync_source_select_in;

  // Values each module exports for its partner and the outputs
  wire [CW-1:0] cnt_w  [0:1];
  wire [CW-1:0] buf_w  [0:1];
  wire [1:0]    hold_own_v;
  wire [1:0]    clr_own_v;
  wire [1:0]    inc_own_v;
  wire [1:0]    cap_own_v;
  wire [1:0]    full_v;
  wire [1:0]    bne_v;
  wire [1:0]    ov_v;
  wire [1:0]    ts_v;
  wire [1:0]    irq_v;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : chan
      reg  [CW-1:0] cnt_q;
      reg           pin_q;
      reg     [3:0] pre_q;
      reg     [1:0] icnt_q;
      reg           ts_q;
      reg           armed_q;
      reg           ov_q;
      reg           irq_q;
      reg           edge_hit;
      wire          carry;
      wire          follow;
      wire          off;
      wire          no_count;
      wire          sync_m;
      wire          trig_m;
      wire          sync_ev;
      wire          tick;
      wire          hold_e;
      wire          clr_e;
      wire          inc_e;
      wire          cap_e;
      wire          full_any;
      wire          push;
      wire          rise;
      wire          fall;
      wire          pre_mode;
      wire          rate_hit;
      wire          wake_ev;

      // Even module is carried by the odd one when the pair is joined
      assign carry  = (i == 1) && casc;
      assign follow = carry && !trig_v[i];

      // Off codes stop capture; wake mode keeps the counter clear too
      assign off      = (mode_w[i] == `MODE_OFF) || (mode_w[i] == `MODE_UNUSED);
      assign no_count = off || (mode_w[i] == `MODE_WAKE);

      // Sync or trigger selection from source code and trigger bit
      assign sync_m  = (sel_w[i] != `SYNC_NONE) && !trig_v[i];
      assign trig_m  = trig_v[i];
      assign sync_ev = (sel_w[i] != `SYNC_NONE) && sync_events_in[sel_w[i]];

      // Six usable time base codes; reserved codes never tick
      assign tick = time_base_ticks_in[tbsel_w[i]]
                    && (tbsel_w[i] != `TB_RSVD_A)
                    && (tbsel_w[i] != `TB_RSVD_B);

      // Counter held clear while off, untriggered, or cascaded sync not yet seen
      assign hold_own_v[i] = no_count
                             || (trig_m && !ts_q)
                             || (casc && sync_m && !armed_q);
      assign clr_own_v[i]  = sync_m && sync_ev;
      assign hold_e = follow ? hold_own_v[0] : hold_own_v[i];
      assign clr_e  = follow ? clr_own_v[0] : clr_own_v[i];

      // Own increment; in cascade the even word counts odd wraps
      assign inc_own_v[i] = tick && !hold_e;
      assign inc_e = carry ? (inc_own_v[0] && (cnt_w[0] == `CNT_MAX) && !hold_e)
                           : inc_own_v[i];

      // Time base counter, cleared while held or on sync clear, else counting ticks with natural wrap
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          cnt_q <= `CNT_ZERO;
        end
        else if (hold_e || clr_e)
        begin
          cnt_q <= `CNT_ZERO;
        end
        else if (inc_e)
        begin
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
      assign cnt_w[i] = cnt_q;

      // Trigger status: hardware or software sets, software clears, set wins
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          ts_q <= 1'b0;
        end
        else
        begin
          ts_q <= (ts_q && !tclr_v[i]) || tset_v[i] || (trig_m && sync_ev);
        end
      end
      assign ts_v[i] = ts_q;

      // Remembers that the sync source has produced an event
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          armed_q <= 1'b0;
        end
        else if (!sync_m)
        begin
          armed_q <= 1'b0;
        end
        else if (sync_ev)
        begin
          armed_q <= 1'b1;
        end
      end

      // Pin edge detection
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          pin_q <= 1'b0;
        end
        else
        begin
          pin_q <= pin_v[i];
        end
      end
      assign rise     = pin_v[i] && !pin_q;
      assign fall     = !pin_v[i] && pin_q;
      assign pre_mode = (mode_w[i] == `MODE_PRE4) || (mode_w[i] == `MODE_PRE16);

      // Rising edge prescaler for every 4th or 16th capture
      always @(posedge clk_in)
      begin
        if (rst_in || !pre_mode || hold_e)
        begin
          pre_q <= `PRE_ZERO;
        end
        else if (rise)
        begin
          if (edge_hit)
          begin
            pre_q <= `PRE_ZERO;
          end
          else
          begin
            pre_q <= pre_q + 4'h1;
          end
        end
      end

      // Edge qualification per mode
      always @*
      begin
        case (mode_w[i])
          `MODE_EVERY: edge_hit = rise || fall;
          `MODE_FALL:  edge_hit = fall;
          `MODE_RISE:  edge_hit = rise;
          `MODE_PRE4:  edge_hit = rise && (pre_q == `PRE4_LAST);
          `MODE_PRE16: edge_hit = rise && (pre_q == `PRE16_LAST);
          default:     edge_hit = 1'b0;
        endcase
      end

      // Capture event; in cascade the odd event stores both words
      assign cap_own_v[i] = edge_hit && !hold_e && !off;
      assign cap_e    = carry ? cap_own_v[0] : cap_own_v[i];
      assign full_any = full_v[i] || (carry && full_v[0]);
      assign push     = cap_e && !full_any;

      // Overflow: set on a dropped capture, cleared by turning the module off
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          ov_q <= 1'b0;
        end
        else
        begin
          ov_q <= (ov_q && !off) || (cap_e && full_any);
        end
      end
      assign ov_v[i] = ov_q;

      // Interrupt after the programmed number of captures, after every capture in every-edge mode, or on a wake edge
      assign rate_hit = (mode_w[i] == `MODE_EVERY) || (icnt_q == cpi_w[i]);
      assign wake_ev  = (mode_w[i] == `MODE_WAKE) && sleep_in && rise;
      always @(posedge clk_in)
      begin
        if (rst_in || off || hold_e)
        begin
          icnt_q <= `ICNT_ZERO;
        end
        else if (cap_e)
        begin
          icnt_q <= rate_hit ? `ICNT_ZERO : icnt_q + 2'h1;
        end
      end

      // Interrupt pulse register; the even module is silent in cascade
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          irq_q <= 1'b0;
        end
        else
        begin
          irq_q <= !carry && (wake_ev || (cap_e && rate_hit));
        end
      end
      assign irq_v[i] = irq_q;

      // Four-deep capture store
      capture_fifo #(
        .WIDTH (CW),
        .DEPTH (DEPTH),
        .AW    (AW)
      ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .push_in       (push),
        .data_in       (cnt_q),
        .pop_in        (read_v[i]),
        .data_out      (buf_w[i]),
        .not_empty_out (bne_v[i]),
        .full_out      (full_v[i])
      );
    end
  endgenerate

  // Outputs of the odd module
  assign x_buffer_out                 = buf_w[0];
  assign x_buffer_not_empty_flag_out  = bne_v[0];
  assign x_capture_overflow_flag_out  = ov_v[0];
  assign x_trigger_running_status_out = ts_v[0];
  assign x_irq_out                    = irq_v[0];
  assign x_capture_counter_out        = cnt_w[0];

  // Outputs of the even module
  assign y_buffer_out                 = buf_w[1];
  assign y_buffer_not_empty_flag_out  = bne_v[1];
  assign y_capture_overflow_flag_out  = ov_v[1];
  assign y_trigger_running_status_out = ts_v[1];
  assign y_irq_out                    = irq_v[1];
  assign y_capture_counter_out        = cnt_w[1];

endmodule // capture_pair

`default_nettype wire

// [capture_defs.vh]
/*
  Shared constants for the input capture pair: capture mode codes,
  prescaler end counts, source selection codes and counter limits.
  Assumes it is included by bare name from the design files.
*/
`ifndef CAPTURE_DEFS_VH
`define CAPTURE_DEFS_VH

// Capture mode field codes
`define MODE_OFF    3'h0
`define MODE_EVERY  3'h1
`define MODE_FALL   3'h2
`define MODE_RISE   3'h3
`define MODE_PRE4   3'h4
`define MODE_PRE16  3'h5
`define MODE_UNUSED 3'h6
`define MODE_WAKE   3'h7

// Prescaler last counts (every 4th and every 16th rising edge)
`define PRE4_LAST   4'h3
`define PRE16_LAST  4'hf
`define PRE_ZERO    4'h0

// Sync source code meaning no sync and no hardware trigger
`define SYNC_NONE   5'h00

// Reserved time base codes that give no tick
`define TB_RSVD_A   3'h5
`define TB_RSVD_B   3'h6

// Counter limits
`define CNT_MAX     16'hffff
`define CNT_ZERO    16'h0000

// Interrupt event counter start
`define ICNT_ZERO   2'h0

`endif

// [capture_fifo.v]
/*
  Small first-in first-out store of captured counter values.
  Assumes one clock, synchronous active-high reset, and a power-of-two depth.
  A push while full is dropped unless a pop frees a place in the same cycle; the caller flags the overflow.
*/
`timescale 1ns/100ps
`default_nettype none

module capture_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_in,        // System clock
  input  wire             rst_in,        // Synchronous reset, active high
  input  wire             push_in,       // Store data_in this cycle
  input  wire [WIDTH-1:0] data_in,       // Value to store
  input  wire             pop_in,        // Drop the oldest value
  output wire [WIDTH-1:0] data_out,      // Oldest stored value
  output wire             not_empty_out, // At least one value held
  output wire             full_out       // All places taken
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            do_push;
  wire            do_pop;

  // Accept only what fits and only pop what exists
  assign do_pop        = pop_in & (cnt_q != {(AW+1){1'b0}});
  assign do_push       = push_in & ((cnt_q != DEPTH[AW:0]) | do_pop);
  assign full_out      = (cnt_q == DEPTH[AW:0]);
  assign not_empty_out = (cnt_q != {(AW+1){1'b0}});
  assign data_out      = mem[rd_q];

  // Storage writes
  always @(posedge clk_in)
  begin
    if (do_push)
    begin
      mem[wr_q] <= data_in;
    end
  end

  // Pointers and fill count
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
      begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop)
      begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push & ~do_pop)
      begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end
      else if (do_pop & ~do_push)
      begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // capture_fifo

`default_nettype wire

// [capture_pair_chk.sv]
/*
  Concurrent checks on the capture pair's top ports.
  Assumes it is bound into capture_pair from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none
module capture_pair_chk #(
  parameter CW = 16
) (
  input wire logic          clk_in, // System clock
  input wire logic          rst_in, // Synchronous reset
  input wire logic [7:0]    time_base_ticks_in, // Ticks
  input wire logic [31:0]   sync_events_in, // Sync events
  input wire logic          x_pin_in, // Odd pin
  input wire logic [2:0]    x_capture_mode_select_in, // Odd mode
  input wire logic [2:0]    x_time_base_select_in, // Odd clock source
  input wire logic [4:0]    x_sync_source_select_in, // Odd sync source
  input wire logic          x_trigger_not_sync_select_in, // Odd trigger bit
  input wire logic          x_cascade_enable_in, // Odd cascade bit
  input wire logic          y_cascade_enable_in, // Even cascade bit
  input wire logic [CW-1:0] x_buffer_out, // Odd oldest value
  input wire logic          x_buffer_not_empty_flag_out, // Odd not empty
  input wire logic          x_capture_overflow_flag_out, // Odd overflow
  input wire logic          x_trigger_running_status_out, // Odd status
  input wire logic          x_irq_out, // Odd interrupt
  input wire logic [CW-1:0] x_capture_counter_out, // Odd counter
  input wire logic [CW-1:0] y_capture_counter_out // Even counter
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Short aliases and decoded configuration
  wire logic [CW-1:0] cnt  = x_capture_counter_out;
  wire logic          bne  = x_buffer_not_empty_flag_out;
  wire logic          md3  = x_capture_mode_select_in == 3'h3;
  wire logic          free = x_sync_source_select_in == 5'h00 && !x_trigger_not_sync_select_in;
  wire logic          tick = time_base_ticks_in[x_time_base_select_in];
  wire logic          sev  = sync_events_in[x_sync_source_select_in];

  // Rising pin edge in free running rising-edge mode
  sequence rise_seen;
    md3 && free && x_pin_in && !$past(x_pin_in);
  endsequence
  // Trigger mode whose status stays clear for two edges
  sequence trig_idle;
    md3 && x_trigger_not_sync_select_in && !x_trigger_running_status_out ##1 !x_trigger_running_status_out;
  endsequence

  chk_capture_flag: assert property (rise_seen |=> bne)
    else $error("capture did not raise not-empty");
  chk_capture_value: assert property (!bne ##0 rise_seen |=> x_buffer_out == $past(cnt))
    else $error("captured value differs from counter");
  chk_counter_step: assert property (!$stable(cnt) |-> cnt == 16'h0000 || cnt == $past(cnt) + 16'h0001)
    else $error("counter moved other than by one or to zero");
  chk_tick_count: assert property (md3 && free && tick |=> cnt == $past(cnt) + 16'h0001)
    else $error("free running counter missed a tick");
  chk_off_zero: assert property (x_capture_mode_select_in inside {3'h0, 3'h6} |=> cnt == 16'h0000)
    else $error("counter not held clear while off");
  chk_sync_clear: assert property (md3 && x_sync_source_select_in != 5'h00 && !x_trigger_not_sync_select_in && sev
    |=> cnt == 16'h0000)
    else $error("sync event did not clear counter");
  chk_trigger_hold: assert property (trig_idle |-> cnt == 16'h0000)
    else $error("counter ran before trigger");
  chk_irq_after_store: assert property (x_irq_out && $past(x_capture_mode_select_in) != 3'h7 |-> bne)
    else $error("interrupt without stored capture");
  chk_cascade_carry: assert property (x_cascade_enable_in && y_cascade_enable_in && md3 && free && tick
    && cnt == 16'hffff |=> y_capture_counter_out == $past(y_capture_counter_out) + 16'h0001)
    else $error("odd wrap did not carry into even");
  chk_overflow_full: assert property ($rose(x_capture_overflow_flag_out) |-> $past(bne))
    else $error("overflow with empty store");
endmodule // capture_pair_chk
`default_nettype wire

// [pulse_source.sv]
/*
  External pulse source on the capture pin.
  Assumes start_in is a one-cycle request from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
  input  wire logic       clk_in, // System clock
  input  wire logic       start_in, // Begin one high pulse
  input  wire logic [3:0] high_in, // Pulse length in cycles
  output wire logic       pin_out // Level on the pin
);
  logic [3:0] left_q = 4'h0;

  // Counts down the high phase; the line rests low between pulses
  always @(posedge clk_in)
    if (start_in)
      left_q <= #2 high_in;
    else if (left_q != 4'h0)
      left_q <= #2 left_q - 4'h1;
  assign pin_out = left_q != 4'h0;
endmodule // pulse_source
`default_nettype wire

// [tb_top.sv]
/*
  Bench for the capture pair: pulses, ticks and control bits in,
  expected captures queued and compared on every buffer read.
  Assumes the checker and pulse source are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic             clk_in, rst_in, start, tick_all, x_rd, y_rd, set_p, clr_p, x_trig, x_casc, y_casc, pin_prev, ev, sleep;
  logic [2:0]       x_mode, y_mode, x_sel;
  logic [1:0]       x_cpi;
  logic [3:0]       width;
  logic [4:0]       x_sync;
  logic [7:0]       ticks;
  logic [15:0]      mc, ym;
  logic [31:0]      seed, sync_ev, expv;
  logic [31:0]      exp_q[$];
  int               fill, pre, m, cycles, irq_seen, err_count, check_count;
  wire logic        pin, xbne, xovf, xst, xirq;
  wire logic [15:0] xb, xcnt, yb, ycnt;

  pulse_source src (.clk_in(clk_in), .start_in(start), .high_in(width), .pin_out(pin));

  capture_pair dut (.clk_in(clk_in), .rst_in(rst_in), .time_base_ticks_in(ticks), .sync_events_in(sync_ev),
    .sleep_in(sleep), .x_pin_in(pin), .x_capture_mode_select_in(x_mode), .x_captures_per_interrupt_in(x_cpi),
    .x_time_base_select_in(x_sel), .x_sync_source_select_in(x_sync), .x_trigger_not_sync_select_in(x_trig),
    .x_trigger_set_in(set_p), .x_trigger_clr_in(clr_p), .x_cascade_enable_in(x_casc), .x_buffer_read_in(x_rd),
    .y_pin_in(1'b0), .y_capture_mode_select_in(y_mode), .y_captures_per_interrupt_in(2'h0),
    .y_time_base_select_in(x_sel), .y_sync_source_select_in(x_sync),
    .y_trigger_not_sync_select_in(x_trig & ~y_casc), .y_trigger_set_in(1'b0), .y_trigger_clr_in(1'b0),
    .y_cascade_enable_in(y_casc), .y_buffer_read_in(y_rd), .x_buffer_out(xb), .x_buffer_not_empty_flag_out(xbne),
    .x_capture_overflow_flag_out(xovf), .x_trigger_running_status_out(xst), .x_irq_out(xirq),
    .x_capture_counter_out(xcnt), .y_buffer_out(yb), .y_buffer_not_empty_flag_out(),
    .y_capture_overflow_flag_out(), .y_trigger_running_status_out(), .y_irq_out(), .y_capture_counter_out(ycnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check_word(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, want);
    end
  endtask

  task automatic check_flag(input logic got, input logic want);
    check_count++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, want);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  // Random-length pulses from the pin source
  task automatic pulses(input int n);
    repeat (n)
    begin
      seed = xs(seed);
      width = {2'h0, seed[1:0]} + 4'h1;
      start = 1'b1;
      step(1);
      start = 1'b0;
      step(32'(width) + 2);
    end
  endtask

  // Reads until the store reports empty; both words when cascaded
  task automatic read_all;
    repeat (6)
    begin
      x_rd = xbne;
      y_rd = xbne & y_casc;
      step(1);
    end
    x_rd = 1'b0;
    y_rd = 1'b0;
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Random tick pattern and hang limit
  always @(posedge clk_in)
  begin
    seed = xs(seed);
    ticks <= #2 tick_all ? 8'hff : seed[7:0];
    cycles++;
    if (cycles == 72000)
    begin
      err_count++;
      complete_run;
    end
  end

  // Reference counter, even carry and store fill; notes expected captures
  always @(posedge clk_in)
  begin
    if (x_rd && fill > 0)
      fill--;
    if (rst_in || x_mode == 3'h0 || x_mode > 3'h5)
    begin
      mc = 16'h0000;
      ym = 16'h0000;
      pre = 0;
      if (rst_in)
        fill = 0;
    end
    else
    begin
      ev = x_mode == 3'h1 ? pin != pin_prev : x_mode == 3'h2 ? !pin && pin_prev : pin && !pin_prev;
      if (ev && x_mode > 3'h3)
      begin
        pre++;
        ev = pre == (x_mode == 3'h4 ? 4 : 16);
        if (ev)
          pre = 0;
      end
      if (ev && fill < 4)
      begin
        exp_q.push_back({ym, mc});
        fill++;
      end
      if (ticks[x_sel])
      begin
        mc = mc + 16'h0001;
        if (mc == 16'h0000 && x_casc && y_casc)
          ym = ym + 16'h0001;
      end
    end
    pin_prev = pin;
  end

  // Compares each read value with the oldest note; counts interrupts
  always @(posedge clk_in)
  begin
    if (xirq === 1'b1)
      irq_seen++;
    if (!rst_in && x_rd && xbne === 1'b1)
    begin
      expv = exp_q.pop_front();
      check_word(xb, expv[15:0]);
      if (y_rd)
        check_word(yb, expv[31:16]);
    end
  end

  initial
  begin
    {start, tick_all, x_rd, y_rd, set_p, clr_p, x_trig, x_casc, y_casc, pin_prev, sleep} = 11'h000;
    {x_mode, y_mode, x_cpi, x_sync, width, sync_ev} = 49'h0;
    {x_sel, seed, fill, pre, cycles, irq_seen, err_count, check_count} = {3'h7, 32'h0000_000e, 192'h0};
    rst_in = 1'b1;
    step(4);
    rst_in = 1'b0;
    // Each capture mode, its own clock source and interrupt rate
    for (m = 1; m < 6; m++)
    begin
      x_sel = 3'(m - 1);
      x_cpi = 2'(m + 1);
      x_mode = 3'(m);
      repeat (16)
      begin
        pulses(1);
        read_all;
      end
      x_mode = 3'h0;
      step(2);
    end
    check_word(16'(irq_seen), 16'h0036);
    // Five captures into an unread store
    x_sel = 3'h7;
    x_mode = 3'h3;
    pulses(5);
    check_flag(xovf, 1'b1);
    read_all;
    check_flag(xbne, 1'b0);
    check_word(16'(exp_q.size()), 16'h0000);
    x_mode = 3'h0;
    step(1);
    check_flag(xovf, 1'b0);
    check_word(xcnt, 16'h0000);
    // Wake edge while asleep interrupts without capture
    {sleep, x_mode, m} = {1'b1, 3'h7, irq_seen};
    pulses(1);
    check_word(16'(irq_seen - m), 16'h0001);
    check_flag(xbne, 1'b0);
    // Sync event clears a running counter
    tick_all = 1'b1;
    x_sync = 5'h05;
    x_mode = 3'h3;
    step(8);
    sync_ev = 32'h0000_0020;
    step(1);
    sync_ev = 32'h0000_0000;
    check_word(xcnt, 16'h0000);
    x_mode = 3'h0;
    x_trig = 1'b1;
    // Hardware trigger, then software trigger
    for (m = 0; m < 2; m++)
    begin
      x_sync = m[0] ? 5'h00 : 5'h05;
      x_mode = 3'h3;
      step(6);
      check_word(xcnt, 16'h0000);
      sync_ev = m[0] ? 32'h0000_0000 : 32'h0000_0020;
      set_p = m[0];
      step(1);
      sync_ev = 32'h0000_0000;
      set_p = 1'b0;
      step(4);
      check_flag(xst, 1'b1);
      check_flag(xcnt != 16'h0000, 1'b1);
      clr_p = 1'b1;
      step(1);
      clr_p = 1'b0;
      check_flag(xst, 1'b0);
      x_mode = 3'h0;
      step(1);
    end
    x_trig = 1'b0;
    x_sync = 5'h00;
    // Cascaded pair, even module set up first
    y_casc = 1'b1;
    x_casc = 1'b1;
    y_mode = 3'h3;
    x_mode = 3'h3;
    step(65540);
    check_word(ycnt, 16'h0001);
    pulses(1);
    read_all;
    complete_run;
  end
endmodule // tb_top

bind capture_pair capture_pair_chk #(.CW(CW)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .time_base_ticks_in(time_base_ticks_in), .sync_events_in(sync_events_in), .x_pin_in(x_pin_in),
  .x_capture_mode_select_in(x_capture_mode_select_in), .x_time_base_select_in(x_time_base_select_in),
  .x_sync_source_select_in(x_sync_source_select_in), .x_trigger_not_sync_select_in(x_trigger_not_sync_select_in),
  .x_cascade_enable_in(x_cascade_enable_in), .y_cascade_enable_in(y_cascade_enable_in), .x_buffer_out(x_buffer_out),
  .x_buffer_not_empty_flag_out(x_buffer_not_empty_flag_out), .x_capture_overflow_flag_out(x_capture_overflow_flag_out),
  .x_trigger_running_status_out(x_trigger_running_status_out), .x_irq_out(x_irq_out),
  .x_capture_counter_out(x_capture_counter_out), .y_capture_counter_out(y_capture_counter_out));
`default_nettype wire
